/* design/blink_timer.sv */
// periodic lamp pattern generator paced by the common 75 ms tick
module blink_timer
  import logger_ctrl_pkg::*;
(
  input  wire logic       i_core_clk,   // system clock
  input  wire logic       i_reset,      // synchronous reset
  input  wire logic       i_tick,       // 75 ms enable pulse
  input  wire logic       i_restart,    // restart phase at lamp-on
  input  wire logic [7:0] i_period,     // period in ticks
  input  wire logic [7:0] i_on_time,    // on time in ticks
  output logic            o_lamp        // pattern level
);

  logic [7:0] phase_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_restart) begin
      phase_reg <= 8'h00;
    end else if (i_tick) begin
      if (phase_reg >= i_period - 8'h01) begin
        phase_reg <= 8'h00;
      end else begin
        phase_reg <= phase_reg + 8'h01;
      end
    end
  end

  // restart shows the lamp at once, as the check button needs
  assign o_lamp = (phase_reg < i_on_time);

endmodule

/* design/logger_ctrl_pkg.sv */
// shared constants and carriers for the logger session and status lamp
package logger_ctrl_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_MS       = 75;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // pattern figures in milliseconds, counted in 75 ms ticks
  localparam int unsigned USB_PER_MS    = 3000;
  localparam int unsigned USB_ON_MS     = 600;
  localparam int unsigned MID_PER_MS    = 1500;
  localparam int unsigned MID_ON_MS     = 300;
  localparam int unsigned MID_LEN_MS    = 5000;
  localparam int unsigned FAST_PER_MS   = 375;
  localparam int unsigned FAST_ON_MS    = 75;
  localparam int unsigned FAST_LEN_MS   = 10000;

  localparam logic [7:0] USB_PER_T  = 8'(USB_PER_MS / TICK_MS);
  localparam logic [7:0] USB_ON_T   = 8'(USB_ON_MS / TICK_MS);
  localparam logic [7:0] MID_PER_T  = 8'(MID_PER_MS / TICK_MS);
  localparam logic [7:0] MID_ON_T   = 8'(MID_ON_MS / TICK_MS);
  localparam logic [7:0] FAST_PER_T = 8'(FAST_PER_MS / TICK_MS);
  localparam logic [7:0] FAST_ON_T  = 8'(FAST_ON_MS / TICK_MS);
  localparam logic [7:0] MID_LEN_T  = 8'(MID_LEN_MS / TICK_MS);
  localparam logic [7:0] FAST_LEN_T = 8'(FAST_LEN_MS / TICK_MS);

  localparam int unsigned NAME_MAX_CHARS = 16;
  localparam int unsigned CHAN_W         = 16;

  typedef enum logic [2:0] {
    PAT_DARK  = 3'b000,
    PAT_USB   = 3'b001,
    PAT_MID   = 3'b010,
    PAT_FAST  = 3'b011,
    PAT_STEADY = 3'b100
  } pattern_t;

  typedef enum logic [1:0] {
    SES_IDLE  = 2'b00,
    SES_WAIT  = 2'b01,
    SES_RUN   = 2'b10,
    SES_FLUSH = 2'b11
  } session_t;

  // start timestamp: year offset from 2000, month, day, hour, minute, second
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } stamp_t;

  // one record request towards the card writer
  typedef struct packed {
    logic                valid;
    logic                new_file;
    stamp_t              name;
    logic [CHAN_W-1:0]   raw_mv;
  } record_t;

endpackage

/* design/logger_status_ctrl.sv */
// logging session control and status lamp sequencing
// Function
// - usb present: lamp flashes 3 s period, 0.6 s on
// - run switch change: 1.5 s period, 0.3 s on, for 5 s
// - start fails, e.g. no card: fast flash 0.375/0.075 s for 10 s
// - on stop: 1.5 s / 0.3 s flash while final card write runs
// - check button in normal operation: flash at once while held
// - check button while abnormal: fast flash until released
// - no indication active: lamp stays dark
// - first record waits for next interval-aligned time
// - each session opens a new file named by start stamp, never overwrite
// - raw millivolt reading of every active channel always recorded
// - no equation evaluation or storage in the device
// - stored settings hold everything except equations
// - setting file name accepted up to 16 alphanumeric characters
module logger_status_ctrl
  import logger_ctrl_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES // cycles per 75 ms tick
)(
  input  wire logic              i_core_clk,     // 100 MHz clock
  input  wire logic              i_reset,        // synchronous, high
  input  wire logic              i_usb_present,  // usb host pin
  input  wire logic              i_run_sw,       // run switch pin, 1=start
  input  wire logic              i_check_btn,    // check button pin, 1=held
  input  wire logic              i_card_present, // card detect pin
  input  wire logic              i_fault,        // abnormal operation flag
  input  wire logic              i_interval_hit, // aligned interval pulse
  input  wire stamp_t            i_now,          // real-time clock value
  input  wire logic [CHAN_W-1:0] i_raw_mv,       // raw channel reading
  input  wire logic              i_card_busy,    // card writer busy
  input  wire logic              i_rec_ready,    // card writer ready
  input  wire logic [7:0]        i_name_char,    // setting name character
  input  wire logic              i_name_valid,   // character strobe
  input  wire logic              i_name_end,     // end of name strobe
  output logic                   o_led,          // status lamp
  output record_t                o_record,       // record to card
  output logic                   o_logging,      // session active
  output logic                   o_name_ok       // last name accepted
);

  // pins pass three flops; a change counts once stages two and three agree
  logic [2:0] usb_sync_reg, run_sync_reg, btn_sync_reg, card_sync_reg;
  logic       usb_reg, run_reg, btn_reg, card_reg, run_prev_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      usb_sync_reg  <= 3'h0;
      run_sync_reg  <= 3'h0;
      btn_sync_reg  <= 3'h0;
      card_sync_reg <= 3'h0;
    end else begin
      usb_sync_reg  <= {usb_sync_reg[1:0], i_usb_present};
      run_sync_reg  <= {run_sync_reg[1:0], i_run_sw};
      btn_sync_reg  <= {btn_sync_reg[1:0], i_check_btn};
      card_sync_reg <= {card_sync_reg[1:0], i_card_present};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      usb_reg  <= 1'b0;
      run_reg  <= 1'b0;
      btn_reg  <= 1'b0;
      card_reg <= 1'b0;
    end else begin
      if (usb_sync_reg[1] == usb_sync_reg[2]) usb_reg <= usb_sync_reg[2];
      if (run_sync_reg[1] == run_sync_reg[2]) run_reg <= run_sync_reg[2];
      if (btn_sync_reg[1] == btn_sync_reg[2]) btn_reg <= btn_sync_reg[2];
      if (card_sync_reg[1] == card_sync_reg[2]) begin
        card_reg <= card_sync_reg[2];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) run_prev_reg <= 1'b0;
    else         run_prev_reg <= run_reg;
  end

  logic sw_start, sw_stop;
  assign sw_start = run_reg & ~run_prev_reg;
  assign sw_stop  = ~run_reg & run_prev_reg;

  // common 75 ms tick
  logic [23:0] tick_cnt_reg;
  logic        tick;
  assign tick = (tick_cnt_reg == 24'(TICK_DIV - 1));

  always_ff @(posedge i_core_clk) begin
    if (i_reset || tick) tick_cnt_reg <= 24'h000000;
    else                 tick_cnt_reg <= tick_cnt_reg + 24'h000001;
  end

  // session sequencing
  session_t ses_reg;
  logic     start_err;
  assign start_err = sw_start & ~card_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ses_reg <= SES_IDLE;
    end else begin
      case (ses_reg)
        SES_IDLE:  if (sw_start && card_reg) ses_reg <= SES_WAIT;
        SES_WAIT: begin
          if (sw_stop) ses_reg <= SES_IDLE;
          else if (i_interval_hit && i_rec_ready) ses_reg <= SES_RUN;
        end
        SES_RUN:   if (sw_stop) ses_reg <= SES_FLUSH;
        SES_FLUSH: if (!i_card_busy) ses_reg <= SES_IDLE;
        default:   ses_reg <= SES_IDLE;
      endcase
    end
  end

  // start stamp caught at the switch; names a new file per session
  stamp_t stamp_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset)                      stamp_reg <= '0;
    else if (sw_start && card_reg)    stamp_reg <= i_now;
  end

  // raw reading always written; no conversion path exists here
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_record <= '0;
    end else begin
      o_record.valid    <= i_interval_hit && i_rec_ready &&
                           (ses_reg == SES_WAIT || ses_reg == SES_RUN);
      o_record.new_file <= (ses_reg == SES_WAIT);
      o_record.name     <= stamp_reg;
      o_record.raw_mv   <= i_raw_mv;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) o_logging <= 1'b0;
    else         o_logging <= (ses_reg == SES_WAIT) || (ses_reg == SES_RUN);
  end

  // setting name check: at most 16 alphanumeric characters
  logic [4:0] name_len_reg;
  logic       name_bad_reg;
  logic       alnum;
  assign alnum = (i_name_char >= 8'h30 && i_name_char <= 8'h39) ||
                 (i_name_char >= 8'h41 && i_name_char <= 8'h5a) ||
                 (i_name_char >= 8'h61 && i_name_char <= 8'h7a);

  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_name_end) begin
      name_len_reg <= 5'h00;
      name_bad_reg <= 1'b0;
    end else if (i_name_valid) begin
      if (name_len_reg != 5'h1f) name_len_reg <= name_len_reg + 5'h01;
      if (!alnum || name_len_reg >= 5'(NAME_MAX_CHARS)) begin
        name_bad_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset)         o_name_ok <= 1'b0;
    else if (i_name_end) o_name_ok <= ~name_bad_reg &&
                                      (name_len_reg != 5'h00);
  end

  // timed indications: switch change and start error
  logic [7:0] mid_left_reg, fast_left_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mid_left_reg <= 8'h00;
    end else if ((sw_start && card_reg) || sw_stop) begin
      mid_left_reg <= MID_LEN_T;
    end else if (tick && mid_left_reg != 8'h00) begin
      mid_left_reg <= mid_left_reg - 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      fast_left_reg <= 8'h00;
    end else if (start_err) begin
      fast_left_reg <= FAST_LEN_T;
    end else if (tick && fast_left_reg != 8'h00) begin
      fast_left_reg <= fast_left_reg - 8'h01;
    end
  end

  // priority: errors and abnormal check first, then check button, then stop/start/flush, then usb; else dark
  pattern_t pat, pat_reg;
  always_comb begin
    if (fast_left_reg != 8'h00 || (btn_reg && i_fault)) pat = PAT_FAST;
    else if (btn_reg)                                pat = PAT_STEADY;
    else if (mid_left_reg != 8'h00 || ses_reg == SES_FLUSH) pat = PAT_MID;
    else if (usb_reg)                                pat = PAT_USB;
    else                                             pat = PAT_DARK;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) pat_reg <= PAT_DARK;
    else         pat_reg <= pat;
  end

  logic [7:0] per, on_t;
  always_comb begin
    case (pat)
      PAT_USB:    begin per = USB_PER_T;  on_t = USB_ON_T;  end
      PAT_MID:    begin per = MID_PER_T;  on_t = MID_ON_T;  end
      PAT_FAST:   begin per = FAST_PER_T; on_t = FAST_ON_T; end
      PAT_STEADY: begin per = MID_PER_T;  on_t = MID_ON_T;  end
      default:    begin per = MID_PER_T;  on_t = 8'h00;     end
    endcase
  end

  logic lamp;
  blink_timer u_blink (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_tick     (tick),
    .i_restart  (pat != pat_reg),
    .i_period   (per),
    .i_on_time  (on_t),
    .o_lamp     (lamp)
  );

  // the flush pattern stays up until the writer idles, so the card stays in
  always_ff @(posedge i_core_clk) begin
    if (i_reset) o_led <= 1'b0;
    else         o_led <= lamp && (pat != PAT_DARK);
  end

  property p_dark_when_idle;
    @(posedge i_core_clk) disable iff (i_reset)
      (pat_reg == PAT_DARK && pat == PAT_DARK) |=> !o_led;
  endproperty
  a_dark_when_idle: assert property (p_dark_when_idle)
    else $error("lamp lit with no indication");

  property p_err_first;
    @(posedge i_core_clk) disable iff (i_reset)
      (fast_left_reg != 8'h00) |-> (pat == PAT_FAST);
  endproperty
  a_err_first: assert property (p_err_first)
    else $error("error pattern not given priority");

  property p_start_err_len;
    @(posedge i_core_clk) disable iff (i_reset)
      start_err |=> (fast_left_reg == FAST_LEN_T);
  endproperty
  a_start_err_len: assert property (p_start_err_len)
    else $error("start error timer not loaded");

  property p_mid_len;
    @(posedge i_core_clk) disable iff (i_reset)
      sw_stop |=> (mid_left_reg == MID_LEN_T);
  endproperty
  a_mid_len: assert property (p_mid_len)
    else $error("switch change timer not loaded");

  property p_flush_hold;
    @(posedge i_core_clk) disable iff (i_reset)
      (ses_reg == SES_FLUSH && i_card_busy) |=> (ses_reg == SES_FLUSH);
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("flush left while card busy");

  property p_no_early_run;
    @(posedge i_core_clk) disable iff (i_reset)
      (ses_reg == SES_WAIT && !i_interval_hit && !sw_stop) |=>
        (ses_reg == SES_WAIT);
  endproperty
  a_no_early_run: assert property (p_no_early_run)
    else $error("session ran before aligned time");

  property p_btn_fast;
    @(posedge i_core_clk) disable iff (i_reset)
      (btn_reg && i_fault) |-> (pat == PAT_FAST);
  endproperty
  a_btn_fast: assert property (p_btn_fast)
    else $error("abnormal check not fast");

  property p_btn_at_once;
    @(posedge i_core_clk) disable iff (i_reset)
      (pat == PAT_STEADY && pat_reg != PAT_STEADY) |=> ##1 o_led;
  endproperty
  a_btn_at_once: assert property (p_btn_at_once)
    else $error("check lamp not lit at once");

  c_start: cover property (@(posedge i_core_clk) ses_reg == SES_RUN);
  c_flush: cover property (@(posedge i_core_clk) ses_reg == SES_FLUSH);
  c_err:   cover property (@(posedge i_core_clk) start_err);
  c_usb:   cover property (@(posedge i_core_clk) pat == PAT_USB && o_led);

endmodule

/* verif/card_model.sv */
// behavioural memory card and record writer beside the logger control
module card_model
  import logger_ctrl_pkg::*;
#(
  parameter int unsigned BUSY_CYC = 6  // write time of one record
)(
  input  wire logic    i_core_clk,     // system clock
  input  wire logic    i_reset,        // synchronous reset
  input  wire record_t i_record,       // record from the logger
  input  wire logic    i_insert,       // operator holds card in slot
  output logic         o_card_present, // card detect
  output logic         o_card_busy,    // write in progress
  output logic         o_rec_ready,    // can take a record
  output int unsigned  o_n_rec         // records written so far
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] busy_cnt_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      busy_cnt_reg <= 8'h00;
      o_n_rec      <= 0;
    end else if (i_record.valid) begin
      busy_cnt_reg <= 8'(BUSY_CYC);
      o_n_rec      <= o_n_rec + 1;
    end else if (busy_cnt_reg != 8'h00) begin
      busy_cnt_reg <= busy_cnt_reg - 8'h01;
    end
  end

  assign o_card_busy = busy_cnt_reg != 8'h00;
  // no back-to-back records: a slow card refuses until the write ends
  assign o_rec_ready = !o_card_busy && i_insert;
  // card stays seated while a write runs, pulling it then loses data
  assign o_card_present = i_insert || o_card_busy;
endmodule

/* verif/tb_top.sv */
// self-checking bench for the logger session and lamp control
module tb_top
  import logger_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              usb = 1'b0, run = 1'b0, btn = 1'b0, fault = 1'b0;
  logic              hit = 1'b0, nv = 1'b0, ne = 1'b0, insert = 1'b0;
  stamp_t            now = '0;
  logic [CHAN_W-1:0] mv = '0;
  logic [7:0]        nc = 8'h00;
  logic              card_busy, rec_ready, card_present;
  logic              led, logging, name_ok;
  record_t           rec;
  int unsigned       n_rec;
  int                n_fail = 0, num_checks = 0, cyc = 0;

  always #5 clk = ~clk;

  // short tick keeps lamp timing inside the run; ratios stay as built
  logger_status_ctrl #(.TICK_DIV(20)) dut (.i_core_clk(clk), .i_reset(rst),
    .i_usb_present(usb), .i_run_sw(run), .i_check_btn(btn),
    .i_card_present(card_present), .i_fault(fault),
    .i_interval_hit(hit), .i_now(now), .i_raw_mv(mv),
    .i_card_busy(card_busy), .i_rec_ready(rec_ready),
    .i_name_char(nc), .i_name_valid(nv), .i_name_end(ne),
    .o_led(led), .o_record(rec), .o_logging(logging),
    .o_name_ok(name_ok));

  // slow card so that a stop lands while the last write still runs
  card_model #(.BUSY_CYC(30)) card (.i_core_clk(clk), .i_reset(rst),
    .i_record(rec),
    .i_insert(insert), .o_card_present(card_present),
    .o_card_busy(card_busy), .o_rec_ready(rec_ready), .o_n_rec(n_rec));

  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // sample one step after the edge so registered outputs have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_led(input logic exp, input int lim = 12);
    for (int i = 0; i < lim && led !== exp; i++) wait_cyc(1);
    check(64'(led), 64'(exp));
  endtask

  task automatic wait_log(input logic exp);
    for (int i = 0; i < 12 && logging !== exp; i++) wait_cyc(1);
    check(64'(logging), 64'(exp));
  endtask

  task automatic log_hit(input logic nf, input stamp_t st,
                         input logic [CHAN_W-1:0] v);
    for (int i = 0; i < 40 && card_busy === 1'b1; i++) wait_cyc(1);
    @(posedge clk);
    mv  <= v;
    hit <= 1'b1;
    @(posedge clk);
    hit <= 1'b0;
    // the record stands for one cycle only, right after this edge
    #1;
    check(64'(rec.valid), 64'h1);
    check(64'(rec.new_file), 64'(nf));
    check(64'(rec.name), 64'(st));
    check(64'(rec.raw_mv), 64'(v));
    wait_cyc(1);
    check(64'(rec.valid), 64'h0);
    wait_cyc(10);
  endtask

  task automatic t_dark;
    int bad;
    bad = 0;
    repeat (20) begin
      wait_cyc(1);
      if (led !== 1'b0 || rec.valid !== 1'b0) bad++;
    end
    check(64'(bad), 64'h0);
  endtask

  task automatic t_usb;
    @(posedge clk) usb <= 1'b1;
    wait_led(1'b1);
    wait_cyc(20);
    check(64'(led), 64'h1);
    wait_led(1'b0, 200);
    @(posedge clk) usb <= 1'b0;
    wait_led(1'b0);
  endtask

  task automatic t_button;
    @(posedge clk) btn <= 1'b1;
    wait_led(1'b1);
    @(posedge clk) btn <= 1'b0;
    wait_led(1'b0);
    @(posedge clk) fault <= 1'b1;
    wait_cyc(10);
    check(64'(led), 64'h0);
    @(posedge clk) btn <= 1'b1;
    wait_led(1'b1);
    wait_led(1'b0, 30);
    wait_led(1'b1, 90);
    @(posedge clk) btn <= 1'b0;
    wait_led(1'b0);
    @(posedge clk) fault <= 1'b0;
  endtask

  task automatic send_name(input string s, input logic exp);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      nc <= s[i];
      nv <= 1'b1;
    end
    @(posedge clk);
    nv <= 1'b0;
    ne <= 1'b1;
    @(posedge clk);
    ne <= 1'b0;
    wait_cyc(2);
    check(64'(name_ok), 64'(exp));
  endtask

  task automatic t_names;
    send_name("Abcdefgh12345678", 1'b1);
    send_name("", 1'b0);
    send_name("Z9", 1'b1);
    send_name("ab@c", 1'b0);
    send_name("x", 1'b1);
    send_name("a[", 1'b0);
    send_name("q0", 1'b1);
    send_name("a:", 1'b0);
    send_name("Abcdefgh123456789", 1'b0);
  endtask

  task automatic t_no_card;
    int unsigned n0;
    n0 = n_rec;
    @(posedge clk) run <= 1'b1;
    wait_led(1'b1);
    wait_cyc(30);
    check(64'(logging), 64'h0);
    @(posedge clk) hit <= 1'b1;
    @(posedge clk) hit <= 1'b0;
    wait_cyc(5);
    check(64'(n_rec), 64'(n0));
    @(posedge clk) run <= 1'b0;
    wait_cyc(10);
    // fast flash outlives the 5 s stop flash, then ends after 10 s
    wait_cyc(2400);
    wait_led(1'b1, 120);
    wait_cyc(300);
    check(64'(led), 64'h0);
  endtask

  task automatic t_session(input stamp_t st, input logic [CHAN_W-1:0] v);
    int unsigned n0;
    @(posedge clk) insert <= 1'b1;
    now <= st;
    wait_cyc(10);
    @(posedge clk) run <= 1'b1;
    wait_log(1'b1);
    n0 = n_rec;
    @(posedge clk) now <= ~st;
    wait_cyc(20);
    check(64'(n_rec), 64'(n0));
    log_hit(1'b1, st, v);
    log_hit(1'b0, st, ~v);
    @(posedge clk) run <= 1'b0;
    wait_log(1'b0);
    wait_cyc(10);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_dark();
    t_usb();
    t_button();
    t_names();
    t_no_card();
    t_session(stamp_t'(33'h12345678), 16'h1234);
    t_session(stamp_t'(33'h0abcdef1), 16'h0001);
    check(64'(n_rec), 64'd4);
    complete_run();
  end
endmodule
